// >>> hdl/tcf_core.sv
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - fault enable and filter bits write only while write protect disable set
// - fault control bits 7..4 enable filters of fault inputs 3..0
// - fault control bits 3..0 enable fault inputs 3..0
// - everything runs on the single system clock
// - two-bit source select picks one of three clocks or none; resets to none
// - source select always accessible; stopping leaves counter and registers
// - external clock synchronised; must be at most quarter system clock
// - prescaler is a 7-bit counter set by three-bit prescale select
// - 16-bit counter advances at selected clock over prescaler
// - up mode loads start, increments to final, reloads start
// - up period is final minus start plus one counter clocks
// - up mode sets overflow flag on final to start transition
// - start value msb one gives signed counting from negative value
// - final equal start holds counter and flags overflow each tick
// - extended on with zero final and start keeps counter stopped at zero
// - start above final still operated without restriction
// - center align counts up to final then down to start
// - up-down period is twice final minus start counter clocks
// - up-down flags overflow moving from final to final minus one
// - writing either counter byte resets counter to start value
// - extended off with final zero or all ones runs free, flag on wrap
module tcf_core #(
	parameter int PRESCALE_WIDTH = 7
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// counter clock sources
	input wire logic FIXED_CLK_TICK,
	input wire logic EXT_CLK,
	// timer state to the channels and fault unit
	output logic [15:0] COUNT,
	output logic OVERFLOW,
	output tcf_pkg::tcf_fault_ctrl_s FAULT_CTRL
);
	import tcf_pkg::*;

	tcf_bus_req_s req;
	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	logic [2:0] prescale_select_q;
	tcf_clk_src_e clock_source_select_q;
	logic center_align_select_q;
	logic overflow_flag_q;
	logic extended_features_enable_q;
	logic write_protect_disable_q;
	tcf_fault_ctrl_s fault_ctrl_q;
	logic [15:0] count_final_value_q;
	logic [15:0] count_start_value_q;
	logic [15:0] count_q, count_d;
	logic down_q, down_d;
	logic [7:0] rdata_q;
	logic ext_sync1_q, ext_sync2_q, ext_prev_q;
	logic [PRESCALE_WIDTH-1:0] presc_q;
	logic src_tick;
	logic adv;
	logic wrap_hit;
	logic free_run;
	logic stalled;
	logic cnt_write;
	// write decode strobes
	logic wr_sc;
	logic wr_final_hi;
	logic wr_final_lo;
	logic wr_start_hi;
	logic wr_start_lo;
	logic wr_mode;
	logic wr_fault;
	logic tof_clear;
	logic ext_rise;
	logic [PRESCALE_WIDTH-1:0] presc_mask;
	// counter helpers
	logic [15:0] count_inc;
	logic [15:0] count_dec;
	logic at_final;
	logic at_start;
	logic same_ends;
	logic [7:0] rd_mux;

	// two-stage synchroniser; only the second stage is read onward
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ext_sync1_q <= 1'b0;
			ext_sync2_q <= 1'b0;
		end else begin
			ext_sync1_q <= EXT_CLK;
			ext_sync2_q <= ext_sync1_q;
		end
	end

	// history for the edge detect; idle low matches the pin at rest
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_sync2_q;
		end
	end

	// one count per rising edge, three system clocks after the pin
	assign ext_rise = ext_sync2_q & ~ext_prev_q;

	// fixed tick is a system-domain strobe made by the integration
	always_comb begin
		unique case (clock_source_select_q)
			TCF_CLK_NONE: begin
				src_tick = 1'b0;
			end
			TCF_CLK_SYSTEM: begin
				src_tick = 1'b1;
			end
			TCF_CLK_FIXED: begin
				src_tick = FIXED_CLK_TICK;
			end
			TCF_CLK_EXTERNAL: begin
				src_tick = ext_rise;
			end
		endcase
	end

	// prescaler: advance when low select bits of the count are all ones
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			presc_q <= '0;
		end else if (src_tick) begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// mask of the low select bits; all ones there ends one division
	always_comb begin
		presc_mask = '0;
		for (int i = 0; i < PRESCALE_WIDTH; i++) begin
			presc_mask[i] = (i < int'(prescale_select_q));
		end
	end

	assign adv = src_tick &&
		((presc_q & presc_mask) == presc_mask);

	// register write decode, one strobe per target
	assign wr_sc = req.wr && req.addr == TCF_IDX_STATUS_CTRL;
	assign wr_final_hi = req.wr && req.addr == TCF_IDX_FINAL_HIGH;
	assign wr_final_lo = req.wr && req.addr == TCF_IDX_FINAL_LOW;
	assign wr_start_hi = req.wr && req.addr == TCF_IDX_START_HIGH;
	assign wr_start_lo = req.wr && req.addr == TCF_IDX_START_LOW;
	assign wr_mode = req.wr && req.addr == TCF_IDX_MODE;
	assign wr_fault = req.wr && req.addr == TCF_IDX_FAULT_CTRL;
	assign tof_clear = wr_sc && !req.wdata[TCF_SC_TOF_BIT];
	assign cnt_write = req.wr &&
		(req.addr == TCF_IDX_CNT_HIGH || req.addr == TCF_IDX_CNT_LOW);
	assign free_run = !extended_features_enable_q &&
		(count_final_value_q == TCF_RST_WORD ||
		count_final_value_q == TCF_ALL_ONES);
	assign stalled = extended_features_enable_q &&
		count_final_value_q == TCF_RST_WORD &&
		count_start_value_q == TCF_RST_WORD;

	// shared compares and steps for both counting modes
	assign same_ends = count_final_value_q == count_start_value_q;
	assign at_final = count_q == count_final_value_q;
	assign at_start = count_q == count_start_value_q;
	assign count_inc = count_q + 16'h0001;
	assign count_dec = count_q - 16'h0001;

	// next count and direction
	always_comb begin
		count_d = count_q;
		down_d = down_q;
		wrap_hit = 1'b0;
		if (cnt_write) begin
			count_d = count_start_value_q;
			down_d = 1'b0;
		end else if (adv && !stalled) begin
			if (free_run) begin
				count_d = count_inc;
				wrap_hit = (count_q == TCF_ALL_ONES);
			end else if (same_ends) begin
				count_d = count_start_value_q;
				wrap_hit = 1'b1;
			end else if (!center_align_select_q) begin
				// plain equality compare works for signed and start>final
				if (at_final) begin
					count_d = count_start_value_q;
					wrap_hit = 1'b1;
				end else begin
					count_d = count_inc;
				end
			end else begin
				if (!down_q && at_final) begin
					count_d = count_dec;
					down_d = 1'b1;
					wrap_hit = 1'b1;
				end else if (down_q && at_start) begin
					count_d = count_inc;
					down_d = 1'b0;
				end else if (down_q) begin
					count_d = count_dec;
				end else begin
					count_d = count_inc;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			count_q <= TCF_RST_WORD;
		end else begin
			count_q <= count_d;
		end
	end

	// direction only matters in center-aligned counting
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			down_q <= 1'b0;
		end else begin
			down_q <= down_d;
		end
	end

	// overflow flag: set beats the software clear in the same cycle
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			overflow_flag_q <= 1'b0;
		end else if (wrap_hit) begin
			overflow_flag_q <= 1'b1;
		end else if (tof_clear) begin
			overflow_flag_q <= 1'b0;
		end
	end

	// source select on its own; stopping touches nothing else
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			clock_source_select_q <= TCF_CLK_NONE;
		end else if (wr_sc) begin
			clock_source_select_q <= tcf_clk_src_e'(
				req.wdata[TCF_SC_CLOCK_SOURCE_SELECT_LSB +: 2]);
		end
	end

	// divider and counting mode share the status/control byte
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			prescale_select_q <= TCF_RST_PS;
			center_align_select_q <= 1'b0;
		end else if (wr_sc) begin
			prescale_select_q <= req.wdata[TCF_SC_PS_LSB +: 3];
			center_align_select_q <= req.wdata[TCF_SC_CENTER_ALIGN_SELECT_BIT];
		end
	end

	// high and low bytes land independently; no latching of pairs
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			count_final_value_q <= TCF_RST_WORD;
		end else if (wr_final_hi) begin
			count_final_value_q[15:8] <= req.wdata;
		end else if (wr_final_lo) begin
			count_final_value_q[7:0] <= req.wdata;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			count_start_value_q <= TCF_RST_WORD;
		end else if (wr_start_hi) begin
			count_start_value_q[15:8] <= req.wdata;
		end else if (wr_start_lo) begin
			count_start_value_q[7:0] <= req.wdata;
		end
	end

	// write protect disable comes out of reset set, so firmware may configure
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			write_protect_disable_q <= TCF_RST_MODE[TCF_MODE_WRITE_PROTECT_DISABLE_BIT];
		end else if (wr_mode) begin
			write_protect_disable_q <= req.wdata[TCF_MODE_WRITE_PROTECT_DISABLE_BIT];
		end
	end

	// extended features gate the stopped-at-zero and free-run cases
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			extended_features_enable_q <= TCF_RST_MODE[TCF_MODE_EXT_BIT];
		end else if (wr_mode) begin
			extended_features_enable_q <= req.wdata[TCF_MODE_EXT_BIT];
		end
	end

	// fault enables feed the fault unit directly
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			fault_ctrl_q <= TCF_RST_FAULT_CTRL;
		end else if (wr_fault && write_protect_disable_q) begin
			fault_ctrl_q <= req.wdata;
		end
	end

	// read mux kept combinational; only its registered copy leaves
	always_comb begin
		unique case (req.addr)
			TCF_IDX_STATUS_CTRL: begin
				// flag, spare zero, mode, source, divider
				rd_mux = {overflow_flag_q, 1'b0, center_align_select_q,
					clock_source_select_q, prescale_select_q};
			end
			TCF_IDX_CNT_HIGH: begin
				rd_mux = count_q[15:8];
			end
			TCF_IDX_CNT_LOW: begin
				rd_mux = count_q[7:0];
			end
			TCF_IDX_FINAL_HIGH: begin
				rd_mux = count_final_value_q[15:8];
			end
			TCF_IDX_FINAL_LOW: begin
				rd_mux = count_final_value_q[7:0];
			end
			TCF_IDX_START_HIGH: begin
				rd_mux = count_start_value_q[15:8];
			end
			TCF_IDX_START_LOW: begin
				rd_mux = count_start_value_q[7:0];
			end
			TCF_IDX_MODE: begin
				rd_mux = {5'h00, write_protect_disable_q, 1'b0,
					extended_features_enable_q};
			end
			TCF_IDX_FAULT_CTRL: begin
				rd_mux = fault_ctrl_q;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// read data valid the cycle after the strobe only
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// outputs straight from flops

	assign RDATA = rdata_q;
	assign COUNT = count_q;
	assign OVERFLOW = overflow_flag_q;
	assign FAULT_CTRL = fault_ctrl_q;
endmodule // tcf_core
`default_nettype wire

// >>> hdl/tcf_pkg.sv
package tcf_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] TCF_IDX_STATUS_CTRL = 8'h00;
	localparam logic [7:0] TCF_IDX_CNT_HIGH = 8'h01;
	localparam logic [7:0] TCF_IDX_CNT_LOW = 8'h02;
	localparam logic [7:0] TCF_IDX_FINAL_HIGH = 8'h03;
	localparam logic [7:0] TCF_IDX_FINAL_LOW = 8'h04;
	localparam logic [7:0] TCF_IDX_START_HIGH = 8'h05;
	localparam logic [7:0] TCF_IDX_START_LOW = 8'h06;
	localparam logic [7:0] TCF_IDX_MODE = 8'h07;
	localparam logic [7:0] TCF_IDX_FAULT_CTRL = 8'h29;
	// status/control field positions
	localparam int TCF_SC_PS_LSB = 0;
	localparam int TCF_SC_CLOCK_SOURCE_SELECT_LSB = 3;
	localparam int TCF_SC_CENTER_ALIGN_SELECT_BIT = 5;
	localparam int TCF_SC_TOF_BIT = 7;
	// mode field positions
	localparam int TCF_MODE_EXT_BIT = 0;
	localparam int TCF_MODE_WRITE_PROTECT_DISABLE_BIT = 2;
	// reset values and the all-ones compare word
	localparam logic [15:0] TCF_RST_WORD = 16'h0000;
	localparam logic [15:0] TCF_ALL_ONES = 16'hFFFF;
	localparam logic [7:0] TCF_RST_FAULT_CTRL = 8'h00;
	localparam logic [7:0] TCF_RST_MODE = 8'h04;
	localparam logic [2:0] TCF_RST_PS = 3'h0;

	typedef enum logic [1:0] {
		TCF_CLK_NONE,
		TCF_CLK_SYSTEM,
		TCF_CLK_FIXED,
		TCF_CLK_EXTERNAL
	} tcf_clk_src_e;

	typedef struct packed {
		logic [3:0] filter_enable;
		logic [3:0] input_enable;
	} tcf_fault_ctrl_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcf_bus_req_s;
endpackage

// >>> tb/tcf_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tcf_core_bench;
	import tcf_pkg::*;
	logic CORE_CLK, RESETN, WR, RD, FIXED_CLK_TICK, EXT_CLK, rd_d;
	logic [7:0] ADDR, WDATA, RDATA, r;
	logic [15:0] COUNT;
	logic OVERFLOW;
	tcf_fault_ctrl_s FAULT_CTRL;
	logic [1:0] cyc;
	logic [7:0] exp_q[$];
	int n_mismatch, tests_run;
	tcf_core i_dut (.CORE_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.FIXED_CLK_TICK, .EXT_CLK, .COUNT, .OVERFLOW, .FAULT_CTRL);
	task automatic chk(input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// each call drives both strobes once, so calls may follow back to back
	task automatic bus(input logic w, rs, input logic [7:0] a, d);
		WR <= w;
		RD <= rs;
		ADDR <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
	endtask
	task automatic wr(input logic [7:0] a, d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	// counter source live for exactly n cycles; stop keeps the flag
	task automatic run(input logic [7:0] sc, input int n);
		wr(8'h02, 8'h00);
		wr(8'h00, sc);
		repeat (n - 1) bus(1'b0, 1'b0, 8'h00, 8'h00);
		wr(8'h00, 8'h80);
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	// both sources at a quarter of the system clock, the fastest allowed
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 2'h1;
		FIXED_CLK_TICK <= cyc == 2'h0;
		EXT_CLK <= cyc[1];
	end
	always @(posedge CORE_CLK) begin
		rd_d <= RD;
		if (rd_d) chk(RDATA, exp_q.pop_front());
	end
	initial begin
		repeat (10000) @(posedge CORE_CLK);
		n_mismatch++;
		stop_test();
	end
	initial begin
		{RESETN, WR, RD, FIXED_CLK_TICK, EXT_CLK, rd_d} = 6'h00;
		{ADDR, WDATA, cyc} = 18'h0_0000;
		n_mismatch = 0;
		tests_run = 0;
		void'($urandom(65));
		repeat (3) @(posedge CORE_CLK);
		RESETN <= 1'b1;
		rd(8'h29, 8'h00);
		rd(8'h00, 8'h00);
		r = 8'($urandom) | 8'h01;
		wr(8'h07, 8'h00);
		wr(8'h29, r);
		rd(8'h29, 8'h00);
		wr(8'h07, 8'h04);
		for (int i = 0; i < 8; i++) begin
			wr(8'h29, 8'h01 << i);
			rd(8'h29, 8'h01 << i);
		end
		wr(8'h29, r);
		rd(8'h29, r);
		chk(FAULT_CTRL, r);
		$display("test fault control done");
		wr(8'h04, 8'h04);
		run(8'h08, 12);
		rd(8'h02, 8'h02);
		rd(8'h00, 8'h80);
		chk(COUNT[7:0], 8'h02);
		chk({7'h00, OVERFLOW}, 8'h01);
		repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
		rd(8'h02, 8'h02);
		wr(8'h01, 8'hA5);
		rd(8'h02, 8'h00);
		for (int p = 0; p < 8; p++) begin
			run(8'h08 | 8'(p), 7 << p);
			rd(8'h02, 8'h02);
		end
		$display("test up count done");
		wr(8'h04, 8'h03);
		wr(8'h00, 8'h00);
		run(8'h28, 9);
		rd(8'h02, 8'h03);
		rd(8'h00, 8'h80);
		wr(8'h04, 8'h05);
		wr(8'h06, 8'h05);
		wr(8'h00, 8'h00);
		run(8'h08, 3);
		rd(8'h02, 8'h05);
		rd(8'h00, 8'h80);
		$display("test up-down and equal done");
		wr(8'h04, 8'h00);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h05);
		wr(8'h00, 8'h00);
		run(8'h08, 5);
		rd(8'h02, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h07, 8'h04);
		for (int k = 3; k < 7; k++) wr(8'(k), k == 6 ? 8'hFE : 8'hFF);
		run(8'h08, 3);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h01);
		rd(8'h00, 8'h80);
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h04);
		wr(8'h05, 8'hFF);
		wr(8'h06, 8'hFC);
		run(8'h08, 6);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h02);
		wr(8'h05, 8'h00);
		wr(8'h04, 8'h05);
		wr(8'h06, 8'h15);
		run(8'h08, 3);
		rd(8'h02, 8'h18);
		$display("test stopped and free run done");
		for (int k = 3; k < 7; k++) wr(8'(k), k == 4 ? 8'hFF : 8'h00);
		for (int s = 2; s < 4; s++) begin
			run(8'(s << 3), 40);
			rd(8'h02, 8'h0A);
		end
		$display("test clock sources done");
		repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
		stop_test();
	end
endmodule // tcf_core_bench
`default_nettype wire

// >>> tb/tcf_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tcf_core_monitor (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic WR,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic [15:0] COUNT,
	input wire logic OVERFLOW,
	input wire tcf_pkg::tcf_fault_ctrl_s FAULT_CTRL
);
	logic wp_q, cm_q;
	logic [1:0] ck_q;
	logic [2:0] ps_q;
	logic [15:0] st_q, fi_q;
	wire logic w_f = WR && ADDR == 8'h29;
	// only exact with one advance per cycle, so system clock and no divide
	wire logic run0 = ck_q == 2'h1 && ps_q == 3'h0 && !WR && fi_q != st_q;
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			wp_q <= 1'b1;
			{cm_q, ck_q, ps_q} <= 6'h00;
			st_q <= 16'h0000;
			fi_q <= 16'h0000;
		end else if (WR) begin
			case (ADDR)
			8'h00: {cm_q, ck_q, ps_q} <= WDATA[5:0];
			8'h03: fi_q[15:8] <= WDATA;
			8'h04: fi_q[7:0] <= WDATA;
			8'h05: st_q[15:8] <= WDATA;
			8'h06: st_q[7:0] <= WDATA;
			8'h07: wp_q <= WDATA[2];
			default: ;
			endcase
		end
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);
	AST_RST: assert property (disable iff (1'b0)
		!RESETN |=> COUNT == 16'h0000 && !OVERFLOW)
		else $error("reset state wrong");
	AST_WP: assert property (!(w_f && wp_q) |=> $stable(FAULT_CTRL))
		else $error("fault control changed");
	AST_FW: assert property (w_f && wp_q |=> FAULT_CTRL == $past(WDATA))
		else $error("fault control not written");
	AST_LOAD: assert property (
		WR && (ADDR == 8'h01 || ADDR == 8'h02) |=> COUNT == st_q)
		else $error("count write did not load start");
	AST_STOP: assert property (ck_q == 2'h0 && !WR |=> $stable(COUNT))
		else $error("count moved while stopped");
	AST_PRE: assert property (
		$changed(COUNT) && !$past(WR) && ps_q != 3'h0 && !WR
		|=> $stable(COUNT))
		else $error("prescaler advanced twice in a row");
	AST_OVF: assert property ($rose(OVERFLOW) |->
		$past(COUNT) == fi_q || $past(COUNT) == 16'hFFFF)
		else $error("overflow at wrong count");
	AST_UP: assert property (run0 && !cm_q && COUNT != fi_q
		|=> COUNT == $past(COUNT) + 16'h0001)
		else $error("up step wrong");
	AST_WRAP: assert property (run0 && !cm_q && COUNT == fi_q
		&& fi_q != 16'h0000 && fi_q != 16'hFFFF |=> COUNT == st_q && OVERFLOW)
		else $error("wrap to start wrong");
	AST_TURN: assert property (run0 && cm_q && COUNT == fi_q
		|=> COUNT == fi_q - 16'h0001 && OVERFLOW)
		else $error("turn at final wrong");
	cover property (w_f && !wp_q);
	cover property ($rose(OVERFLOW));
	cover property (cm_q && COUNT == fi_q);
endmodule // tcf_core_monitor
bind tcf_core tcf_core_monitor i_mon (.CORE_CLK, .RESETN, .WR, .ADDR,
	.WDATA, .COUNT, .OVERFLOW, .FAULT_CTRL);
`default_nettype wire
